// ==== common/qdfsr_pkg.sv ====
package qdfsr_pkg;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int NCH = 4;
  localparam int NFB = 4;
  localparam int NBITS = 16;

  // fault bit position inside a channel nibble, nibble msb first
  localparam int FB_THERM = 0;
  localparam int FB_SUPPLY = 1;
  localparam int FB_GROUND = 2;
  localparam int FB_OPEN = 3;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  // comparator persistence, in fault-filter clock cycles
  localparam int FILT_CYC = 8;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam int SYNC_W = 25;
  // deselected chip select is the only synchroniser bit that resets high
  localparam logic [SYNC_W-1:0] SYNC_RST = 25'h0100000;
  localparam logic [NBITS-1:0] DIAG_RST = 16'h0000;
  localparam logic [NCH-1:0] CH_RST = 4'h0;
  localparam logic [FILT_CYC-1:0] FILT_RST = 8'h00;

  // ------------------------------------------------------------------
  // frame state, gray along idle -> lead -> shift
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    QDFSR_ST_IDLE  = 2'h0,
    QDFSR_ST_LEAD  = 2'h1,
    QDFSR_ST_SHIFT = 2'h3
  } qdfsr_state_t;

endpackage : qdfsr_pkg

// ==== common/qdfsr_link_if.sv ====
`timescale 1ns/10ps
interface qdfsr_link_if;
  import qdfsr_pkg::*;
  logic [NBITS-1:0] snap;
  logic out_bit;
  logic started;

  modport sys (output snap, input out_bit, input started);
  modport link (input snap, output out_bit, output started);
endinterface : qdfsr_link_if

// ==== rtl/qdfsr_link.sv ====
`timescale 1ns/10ps
module qdfsr_link
  import qdfsr_pkg::*;
(
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic cascade_serial_in_i,
  qdfsr_link_if.link lnk
);

  // ------------------------------------------------------------------
  // serial clock domain, held clear by the deselected chip select
  // ------------------------------------------------------------------
  logic started_ff;
  logic out_bit_ff;
  logic [NBITS-2:0] rem_ff;
  logic din_ff;

  // upstream changes on its rising edge, so take it on the falling one
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      din_ff <= 1'b0;
    end else begin
      din_ff <= cascade_serial_in_i;
    end
  end

  // snapshot is stable from select until the next select, so the first
  // rising edge may read it directly
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      started_ff <= 1'b0;
      out_bit_ff <= 1'b0;
      rem_ff <= DIAG_RST[NBITS-2:0];
    end else if (!started_ff) begin
      started_ff <= 1'b1;
      out_bit_ff <= lnk.snap[NBITS-1]; // see RQ9
      rem_ff <= lnk.snap[NBITS-2:0];
    end else begin
      out_bit_ff <= rem_ff[NBITS-2]; // see RQ18
      rem_ff <= {rem_ff[NBITS-3:0], din_ff}; // see RQ24
    end
  end

  assign lnk.started = started_ff;
  assign lnk.out_bit = out_bit_ff;

endmodule : qdfsr_link

// ==== rtl/qdfsr_top.sv ====
`timescale 1ns/10ps
// Behaviour
// RQ1: error flag register holds the OR of all 16 diagnostic bits.
// RQ2: error flag leads the frame, ORed with gated cascade input.
// RQ3: while the gate is high the cascade input is forwarded to the output.
// RQ4: serial output is driven only while chip select is low.
// RQ5: chip select falling with serial clock low sets the gate.
// RQ6: gate stays set, even after deselect, until the serial clock rises.
// RQ7: error flag captured at chip select fall, held until the next fall.
// RQ8: serial clock high at chip select fall keeps the gate low.
// RQ9: first rising clock clears the gate and shifts out bit one.
// RQ10: host keeps chip select low until all bits are shifted out.
// RQ11: chip select fall copies the 16 diagnostic bits to the shifter.
// RQ12: four fault bits are kept for each of four channels.
// RQ13: thermal fault sets bit one, gates drive off until cooled.
// RQ14: filtered supply short sets bit two and latches drive off.
// RQ15: only the supply short needs an input toggle to restore drive.
// RQ16: off channel with output below ground threshold sets bit three.
// RQ17: off channel with output near mid supply sets bit four.
// RQ18: data beyond the lead bit follows clock idle low, change on rise.
// RQ19: host reads the lead bit before clocking; zero means no faults.
// RQ20: a set lead bit means the host must clock out the whole chain.
// RQ21: shifting the data out clears the on-chip fault summary; here only diag_ff clears, fault_summary_bit_o holds until the next fall.
// RQ22: faults anywhere in a chain reach the last serial output.
// RQ23: first rising clock clears diagnostics; new faults still land.
// RQ24: after each 16 clocks, upstream data is shifted out.
// RQ25: first device of a chain has its cascade input tied low.
// RQ26: comparator faults must persist through a filter; thermal does not.
// RQ27: serial output is released while chip select is high.
// RQ28: frame order is channel one bits one to four first, then on.
module qdfsr_top
  import qdfsr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic cascade_serial_in_i,
  input wire logic [NCH-1:0] chan_in_i,
  input wire logic [NCH-1:0] therm_i,
  input wire logic [NCH-1:0] supply_short_i,
  input wire logic [NCH-1:0] gnd_low_i,
  input wire logic [NCH-1:0] open_mid_i,
  output logic [NCH-1:0] drive_o,
  output logic [NBITS-1:0] diag_o,
  output logic fault_summary_bit_o,
  output logic sdo_o,
  output logic sdo_oe_n_o
);

  // ------------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------------
  qdfsr_link_if lnk ();

  qdfsr_link u_link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .cascade_serial_in_i(cascade_serial_in_i),
    .lnk(lnk)
  );

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic started_s;
  logic out_bit_s;
  logic din_s;
  logic sclk_s;
  logic cs_n_s;
  logic [NCH-1:0] open_s;
  logic [NCH-1:0] gnd_s;
  logic [NCH-1:0] ocur_s;
  logic [NCH-1:0] therm_s;
  logic [NCH-1:0] chan_s;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
    end else if (ce_i) begin
      sync1_ff <= {lnk.started, lnk.out_bit, cascade_serial_in_i, sclk_i,
                   cs_n_i, open_mid_i, gnd_low_i, supply_short_i, therm_i,
                   chan_in_i};
      sync2_ff <= sync1_ff;
    end
  end

  assign {started_s, out_bit_s, din_s, sclk_s, cs_n_s, open_s, gnd_s,
          ocur_s, therm_s, chan_s} = sync2_ff;

  // ------------------------------------------------------------------
  // frame control
  // ------------------------------------------------------------------
  qdfsr_state_t st_ff;
  qdfsr_state_t nxt_st;
  logic gate_ff;
  logic eflag_ff;
  logic [NBITS-1:0] snap_ff;
  logic [NBITS-1:0] diag_ff;
  logic sdo_ff;
  logic sdo_oe_n_ff;
  logic nxt_gate;
  logic nxt_eflag;
  logic nxt_sdo;
  logic [NBITS-1:0] nxt_snap;
  logic [NBITS-1:0] nxt_diag;
  logic [NBITS-1:0] set_vec;

  wire cs_fall = (st_ff == QDFSR_ST_IDLE) && !cs_n_s;
  wire clr_pulse = (st_ff == QDFSR_ST_LEAD) && started_s && !cs_n_s;
  wire diag_any = |diag_ff; // see RQ1
  wire lead_bit = cs_fall ? (diag_any | (!sclk_s & din_s))
                          : (eflag_ff | (gate_ff & din_s)); // see RQ2

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      QDFSR_ST_IDLE: begin
        if (!cs_n_s) begin
          nxt_st = QDFSR_ST_LEAD;
        end
      end
      QDFSR_ST_LEAD: begin
        if (cs_n_s) begin
          nxt_st = QDFSR_ST_IDLE;
        end else if (started_s) begin
          nxt_st = QDFSR_ST_SHIFT;
        end
      end
      QDFSR_ST_SHIFT: begin
        if (cs_n_s) begin
          nxt_st = QDFSR_ST_IDLE;
        end
      end
      default: begin
        nxt_st = QDFSR_ST_IDLE;
      end
    endcase
  end

  // the gate is not reset by deselect, only by the clock going high
  assign nxt_gate = cs_fall ? !sclk_s // see RQ5 see RQ8
                  : (sclk_s ? 1'b0 : gate_ff); // see RQ6 see RQ9
  assign nxt_eflag = cs_fall ? diag_any : eflag_ff; // see RQ7
  assign nxt_snap = cs_fall ? diag_ff : snap_ff; // see RQ11
  // lead bit passes the cascade level through, so a chain ORs its faults
  assign nxt_sdo = (st_ff == QDFSR_ST_SHIFT) ? out_bit_s
                                             : lead_bit; // see RQ3 see RQ22

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st_ff <= QDFSR_ST_IDLE;
      gate_ff <= 1'b0;
      eflag_ff <= 1'b0;
      snap_ff <= DIAG_RST;
      sdo_ff <= 1'b0;
      sdo_oe_n_ff <= 1'b1;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      gate_ff <= nxt_gate;
      eflag_ff <= nxt_eflag;
      snap_ff <= nxt_snap;
      sdo_ff <= nxt_sdo;
      sdo_oe_n_ff <= cs_n_s; // see RQ4 see RQ27
    end
  end

  assign lnk.snap = snap_ff;

  // ------------------------------------------------------------------
  // per-channel fault detection and drive
  // ------------------------------------------------------------------
  logic [NCH-1:0] drive_ff;
  logic [NCH-1:0] oc_lat_ff;
  logic [NCH-1:0] nxt_drive;
  logic [NCH-1:0] nxt_oc_lat;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int B = NBITS - 1 - c * NFB; // see RQ28
    logic [FILT_CYC-1:0] flt_oc_ff;
    logic [FILT_CYC-1:0] flt_gnd_ff;
    logic [FILT_CYC-1:0] flt_open_ff;
    wire oc_hit = &flt_oc_ff;
    wire gnd_hit = &flt_gnd_ff;
    wire open_hit = &flt_open_ff;
    // sensing the divider is only meaningful with the switch open
    wire gnd_raw = gnd_s[c] & !drive_ff[c]; // see RQ16
    wire open_raw = open_s[c] & !drive_ff[c]; // see RQ17

    // a single low sample restarts the persistence count
    always_ff @(posedge clock_i) begin
      if (!reset_n_i) begin
        flt_oc_ff <= FILT_RST;
        flt_gnd_ff <= FILT_RST;
        flt_open_ff <= FILT_RST;
      end else if (ce_i) begin
        flt_oc_ff <= {flt_oc_ff[FILT_CYC-2:0], ocur_s[c]}; // see RQ26
        flt_gnd_ff <= {flt_gnd_ff[FILT_CYC-2:0], gnd_raw};
        flt_open_ff <= {flt_open_ff[FILT_CYC-2:0], open_raw};
      end
    end

    // latch only falls while the input is off; a set in that cycle wins
    assign nxt_oc_lat[c] = oc_hit | (oc_lat_ff[c] & chan_s[c]); // see RQ14
    assign nxt_drive[c] = chan_s[c] & !therm_s[c] // see RQ13
                        & !oc_hit & !oc_lat_ff[c]; // see RQ15
    assign set_vec[B - FB_THERM] = therm_s[c]; // see RQ12 see RQ13
    assign set_vec[B - FB_SUPPLY] = oc_hit;
    assign set_vec[B - FB_GROUND] = gnd_hit;
    assign set_vec[B - FB_OPEN] = open_hit;
  end

  // new faults win over the readout clear
  assign nxt_diag = set_vec | (diag_ff & {NBITS{!clr_pulse}}); // see RQ23 see RQ21

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      drive_ff <= CH_RST;
      oc_lat_ff <= CH_RST;
      diag_ff <= DIAG_RST;
    end else if (ce_i) begin
      drive_ff <= nxt_drive;
      oc_lat_ff <= nxt_oc_lat;
      diag_ff <= nxt_diag;
    end
  end

  assign drive_o = drive_ff;
  assign diag_o = diag_ff;
  assign fault_summary_bit_o = eflag_ff;
  assign sdo_o = sdo_ff;
  assign sdo_oe_n_o = sdo_oe_n_ff;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  eflag_capture_a: // see RQ1 see RQ7
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && cs_fall) |=> (eflag_ff == $past(diag_any)))
    else $error("error flag not captured at select");

  eflag_hold_a: // see RQ7
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !cs_fall |=> $stable(eflag_ff))
    else $error("error flag changed outside select fall");

  snap_load_a: // see RQ11
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && cs_fall) |=> (snap_ff == $past(diag_ff)))
    else $error("shifter snapshot not loaded at select");

  gate_set_a: // see RQ5
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && cs_fall && !sclk_s) |=> gate_ff)
    else $error("gate not set at select with clock low");

  gate_block_a: // see RQ8
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && cs_fall && sclk_s) |=> !gate_ff)
    else $error("gate set although clock was high");

  gate_hold_a: // see RQ6
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (gate_ff && !sclk_s && !cs_fall) |=> gate_ff)
    else $error("gate dropped while clock stayed low");

  gate_clear_a: // see RQ9
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && sclk_s && !cs_fall) |=> !gate_ff)
    else $error("gate not cleared by rising clock");

  sdo_release_a: // see RQ4 see RQ27
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && cs_n_s) |=> sdo_oe_n_o ##1 (sdo_oe_n_o || !cs_n_s))
    else $error("serial output driven while deselected");

  lead_bit_a: // see RQ2 see RQ3
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && st_ff == QDFSR_ST_LEAD) |=>
      (sdo_o == ($past(eflag_ff) | ($past(gate_ff) & $past(din_s)))))
    else $error("lead bit is not flag OR gated cascade");

  therm_off_a: // see RQ13
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i |=> ((drive_o & $past(therm_s)) == CH_RST))
    else $error("channel driven during thermal fault");

  supply_latch_a: // see RQ14 see RQ15
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i |=> ((drive_o & $past(oc_lat_ff)) == CH_RST))
    else $error("channel driven while supply short latched");

  fault_keep_a: // see RQ23
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ce_i |=> ((diag_ff & $past(set_vec)) == $past(set_vec)))
    else $error("new fault lost");

  diag_clear_a: // see RQ23 see RQ21
  assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ce_i && clr_pulse && set_vec == DIAG_RST) |=> (diag_ff == DIAG_RST))
    else $error("diagnostics not cleared by first clock");

endmodule : qdfsr_top

// ==== testbench/qdfsr_upstream_model.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// upstream cascade device: lead bit, then 16 bits msb first
// ------------------------------------------------------------------
module qdfsr_upstream_model (
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic lead_i,
  input wire logic [15:0] data_i,
  output logic dout_o
);
  logic [15:0] shift_ff = 16'h0000;
  logic bit_ff = 1'b0;
  logic cs_q = 1'b1;
  int cnt = 0;

  assign dout_o = bit_ff;

  // one process owns the line: select edges and leading clock edges
  always @(cs_n_i or posedge sclk_i) begin
    if (cs_n_i !== cs_q) begin
      cs_q <= cs_n_i;
      if (!cs_n_i) begin
        shift_ff <= data_i;
        cnt <= 0;
        bit_ff <= lead_i;
      end else begin
        // released line shows the inverse of its last bit, never a held value
        bit_ff <= ~bit_ff;
      end
    end else if (!cs_n_i) begin
      // data changes on the leading edge so the reader takes it on the trailing
      if (cnt < 16) begin
        bit_ff <= shift_ff[15];
        shift_ff <= {shift_ff[14:0], 1'b0};
      end else begin
        // first device of the chain: its own cascade input is tied low
        bit_ff <= 1'b0;
      end
      cnt <= cnt + 1;
    end
  end
endmodule : qdfsr_upstream_model

// ==== testbench/tb_qdfsr_top.sv ====
`timescale 1ns/10ps
module tb_qdfsr_top;
  import qdfsr_pkg::*;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic sclk_i = 1'b0;
  logic cs_n_i = 1'b1;
  logic cascade_serial_in_i;
  logic up_lead = 1'b1;
  logic [15:0] up_data = 16'hA5C3;
  logic [NCH-1:0] chan_in_i = 4'hF;
  logic [NCH-1:0] therm_i = 4'h0;
  logic [NCH-1:0] supply_short_i = 4'h0;
  logic [NCH-1:0] gnd_low_i = 4'h0;
  logic [NCH-1:0] open_mid_i = 4'h0;
  logic [NCH-1:0] drive_o;
  logic [NBITS-1:0] diag_o;
  logic fault_summary_bit_o;
  logic sdo_o;
  logic sdo_oe_n_o;
  wire sdo_line = sdo_oe_n_o ? 1'bz : sdo_o;
  logic lead;
  logic [31:0] data;
  int failures = 0;
  int checks_done = 0;

  always #2 clock_i = ~clock_i;

  qdfsr_top i_dut (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .cascade_serial_in_i(cascade_serial_in_i),
    .chan_in_i(chan_in_i),
    .therm_i(therm_i),
    .supply_short_i(supply_short_i),
    .gnd_low_i(gnd_low_i),
    .open_mid_i(open_mid_i),
    .drive_o(drive_o),
    .diag_o(diag_o),
    .fault_summary_bit_o(fault_summary_bit_o),
    .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o)
  );

  qdfsr_upstream_model i_up (
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .lead_i(up_lead),
    .data_i(up_data),
    .dout_o(cascade_serial_in_i)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  // one selection: lead bit first, then nclk serial clocks of 160 ns
  task frame(input logic hi, input int nclk, output logic ld,
             output logic [31:0] d);
    int k;
    d = 32'h0;
    @(negedge clock_i);
    sclk_i = hi;
    chk({31'h0, sdo_oe_n_o}, 32'h1, "released");
    cyc(1);
    cs_n_i = 1'b0;
    k = 0;
    while (sdo_oe_n_o !== 1'b0 && k < 10) begin
      cyc(1);
      k++;
    end
    if (k == 10) begin
      failures++;
      give_verdict;
    end
    cyc(3);
    ld = sdo_line;
    sclk_i = 1'b0;
    #1.3;
    for (k = 0; k < nclk; k++) begin
      sclk_i = 1'b1;
      #79.0;
      d = {d[30:0], sdo_line};
      #1.0;
      sclk_i = 1'b0;
      #80.0;
    end
    @(negedge clock_i);
    cs_n_i = 1'b1;
    cyc(5);
    chk({31'h0, sdo_oe_n_o}, 32'h1, "release");
  endtask : frame

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    cyc(4);
    chk({9'h0, drive_o, diag_o, fault_summary_bit_o, sdo_o, sdo_oe_n_o},
        32'h1, "reset");
    reset_n_i = 1'b1;
    cyc(3);
    frame(1'b0, 32, lead, data);
    chk({31'h0, lead}, 32'h1, "cascade lead");
    chk(data, 32'h0000A5C3, "idle chain");
    chk({31'h0, fault_summary_bit_o}, 32'h0, "no flag");
    frame(1'b1, 0, lead, data);
    chk({31'h0, lead}, 32'h0, "gate held low");
    $display("test chain done");
    therm_i = 4'hF;
    cyc(5);
    chk({28'h0, drive_o}, 32'h0, "therm off");
    chk({16'h0, diag_o}, 32'h8888, "therm bits");
    therm_i = 4'h0;
    cyc(5);
    chk({28'h0, drive_o}, 32'hF, "therm cool");
    frame(1'b0, 32, lead, data);
    chk({31'h0, lead}, 32'h1, "flag lead");
    chk(data, 32'h8888A5C3, "therm frame");
    chk({31'h0, fault_summary_bit_o}, 32'h1, "flag held");
    chk({16'h0, diag_o}, 32'h0, "diag cleared");
    up_lead = 1'b0;
    frame(1'b0, 0, lead, data);
    chk({31'h0, lead}, 32'h0, "lead clear");
    chk({31'h0, fault_summary_bit_o}, 32'h0, "flag new");
    $display("test thermal done");
    supply_short_i = 4'hF;
    cyc(5);
    supply_short_i = 4'h0;
    cyc(14);
    chk({12'h0, drive_o, diag_o}, 32'hF0000, "glitch");
    supply_short_i = 4'hF;
    cyc(14);
    chk({12'h0, drive_o, diag_o}, 32'h04444, "short");
    supply_short_i = 4'h0;
    cyc(5);
    chk({28'h0, drive_o}, 32'h0, "latched");
    chan_in_i = 4'h0;
    cyc(5);
    chan_in_i = 4'hF;
    cyc(5);
    chk({28'h0, drive_o}, 32'hF, "toggle");
    gnd_low_i = 4'hF;
    open_mid_i = 4'hF;
    cyc(14);
    chk({16'h0, diag_o}, 32'h4444, "on ignores");
    gnd_low_i = 4'h0;
    open_mid_i = 4'h0;
    therm_i = 4'hF;
    cyc(4);
    frame(1'b0, 32, lead, data);
    chk(data, 32'hCCCCA5C3, "short frame");
    chk({16'h0, diag_o}, 32'h8888, "new fault");
    therm_i = 4'h0;
    $display("test short done");
    chan_in_i = 4'h0;
    gnd_low_i = 4'hF;
    open_mid_i = 4'hF;
    cyc(14);
    chk({16'h0, diag_o}, 32'hBBBB, "off faults");
    gnd_low_i = 4'h0;
    open_mid_i = 4'h0;
    cyc(1);
    frame(1'b0, 32, lead, data);
    chk({31'h0, lead}, 32'h1, "off lead");
    chk(data, 32'hBBBBA5C3, "off frame");
    $display("test off faults done");
    ce_i = 1'b0;
    therm_i = 4'hF;
    cyc(6);
    chk({12'h0, drive_o, diag_o}, 32'h0, "frozen");
    ce_i = 1'b1;
    cyc(5);
    chk({16'h0, diag_o}, 32'h8888, "resumed");
    therm_i = 4'h0;
    $display("test enable done");
    give_verdict;
  end
endmodule : tb_qdfsr_top
